// File: hdl/dpi_pkg.sv
// What this block does
// - Activate opens row from address lines
// - Column on low lines, auto-precharge on line ten
// - Group select bits pick the target bank
// - Registered termination control switches termination
// - Strobes travel with data both ways
// - Read strobe edge-aligned, write strobe centred
// - Each byte strobe times its own byte
// - Complement strobe only in differential mode
// - Chip select high masks the command
// - Command decoded from select and strobes
// - Masked write bytes are not stored
// - One mask value per data beat
// - Inputs sampled on rising link clock
// - Clock enable low blocks commands and write beats
package dpi_pkg;
	localparam int unsigned ADDR_W = 13;
	localparam int unsigned BANK_W = 2;
	localparam int unsigned BANKS = 4;
	localparam int unsigned DQ_W = 16;
	localparam int unsigned LANES = 2;
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned MEM_AW = 4;
	localparam int unsigned AP_BIT = 10;
	localparam int unsigned DIFF_BIT = 10;
	localparam logic [2:0] CMD_MRS = 3'h0;
	localparam logic [2:0] CMD_PRE = 3'h2;
	localparam logic [2:0] CMD_ACT = 3'h3;
	localparam logic [2:0] CMD_WR = 3'h4;
	localparam logic [2:0] CMD_RD = 3'h5;
	localparam logic [1:0] CFG1_SEL = 2'h1;
	localparam logic [1:0] BURST_LAST = 2'h3;
	localparam logic [1:0] RD_WAIT_CYCLES = 2'h2;
	localparam logic [1:0] LRST_INIT = 2'h3;
	localparam logic [BANKS-1:0] OPEN_RST = 4'h0;
	typedef enum logic [1:0] {RD_IDLE, RD_WAIT, RD_BURST} dpi_rd_state_t;
endpackage

// File: hdl/dpi_lane_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dpi_lane_mem #(
	parameter int unsigned W = 8,
	parameter int unsigned AW = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata,
	input wire logic [AW-1:0] i_raddr,
	output logic [W-1:0] o_rdata
);
	typedef struct packed {
		logic [(1<<AW)-1:0][W-1:0] mem;
		logic [W-1:0] rdata;
	} dpi_mem_st_t;
	dpi_mem_st_t q, d;
	always_comb
	begin
		d = q;
		if (i_we)
			d.mem[i_waddr] = i_wdata;
		// Read sees the old word on a same-address write
		d.rdata = q.mem[i_raddr];
	end
	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
			q <= '0;
		else
			q <= d;
	end
	assign o_rdata = q.rdata;
endmodule // dpi_lane_mem
`default_nettype wire

// File: hdl/dpi_top.sv
`timescale 1ns/1ps
`default_nettype none
module dpi_top (
	input wire logic i_mclk,
	input wire logic i_rst,
	input wire logic i_link_clk,
	input wire logic i_cke,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic [dpi_pkg::BANK_W-1:0] i_group_select_bits,
	input wire logic [dpi_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_on_die_termination_control,
	input wire logic [dpi_pkg::DQ_W-1:0] i_data_lines,
	input wire logic i_lower_byte_write_mask,
	input wire logic i_upper_byte_write_mask,
	input wire logic i_lower_byte_strobe,
	input wire logic i_lower_byte_strobe_n,
	input wire logic i_upper_byte_strobe,
	input wire logic i_upper_byte_strobe_n,
	output logic [dpi_pkg::DQ_W-1:0] o_data_lines,
	output logic o_data_lines_oe,
	output logic o_lower_byte_strobe,
	output logic o_lower_byte_strobe_n,
	output logic o_lower_byte_strobe_oe,
	output logic o_lower_byte_strobe_n_oe,
	output logic o_upper_byte_strobe,
	output logic o_upper_byte_strobe_n,
	output logic o_upper_byte_strobe_oe,
	output logic o_upper_byte_strobe_n_oe,
	output logic o_term_enable,
	output logic [dpi_pkg::BANKS-1:0] o_open_banks,
	output logic o_diff_strobe_mode,
	output logic o_term_status
);
	import dpi_pkg::*;

	typedef struct packed {
		logic cke_q;
		logic cs_n_q;
		logic [2:0] cmd_q;
		logic [BANK_W-1:0] ba_q;
		logic [ADDR_W-1:0] addr_q;
		logic term_req_q;
		logic [DQ_W-1:0] dq_q;
		logic [LANES-1:0] wmask_q;
		logic [LANES-1:0] strb_q;
		logic [LANES-1:0] strb_n_q;
		logic [LANES-1:0] strb_prev;
		logic term_on;
		logic diff_mode;
		logic [BANKS-1:0] row_open;
		logic [BANKS-1:0][ADDR_W-1:0] open_row;
		dpi_rd_state_t rd_state;
		logic [1:0] lat_cnt;
		logic [1:0] rd_beat;
		logic [MEM_AW-1:0] rd_addr;
		logic [DQ_W-1:0] dq_out;
		logic dq_oe;
		logic [LANES-1:0] strb_out;
		logic [LANES-1:0] strb_out_n;
		logic strb_oe;
		logic strbn_oe;
		logic [LANES-1:0] wr_act;
		logic [LANES-1:0][1:0] wr_beat;
		logic [MEM_AW-1:0] wr_base;
	} dpi_link_st_t;

	typedef struct packed {
		logic [BANKS-1:0] banks_s1;
		logic [BANKS-1:0] banks_s2;
		logic diff_s1;
		logic diff_s2;
		logic term_s1;
		logic term_s2;
	} dpi_main_st_t;

	dpi_link_st_t lq, ld;
	dpi_main_st_t mq, md;
	logic [1:0] lrst_q;
	logic lk_rst;
	logic cmd_ok;
	logic [LANES-1:0] vs;
	logic [LANES-1:0] edge_seen;
	logic [LANES-1:0] lane_we;
	logic [LANES-1:0][MEM_AW-1:0] lane_waddr;
	logic [DQ_W-1:0] rdata;

	// Release of the link reset is timed to the link clock
	always_ff @(posedge i_link_clk or posedge i_rst)
	begin
		if (i_rst)
			lrst_q <= LRST_INIT;
		else
			lrst_q <= {lrst_q[0], 1'b0};
	end
	assign lk_rst = lrst_q[1];

	genvar gl;
	generate
		for (gl = 0; gl < LANES; gl++)
		begin : g_lane
			dpi_lane_mem #(.W(BYTE_W), .AW(MEM_AW)) u_mem (
				.i_clk(i_link_clk),
				.i_rst(lk_rst),
				.i_we(lane_we[gl]),
				.i_waddr(lane_waddr[gl]),
				.i_wdata(lq.dq_q[gl*BYTE_W +: BYTE_W]),
				.i_raddr(ld.rd_addr),
				.o_rdata(rdata[gl*BYTE_W +: BYTE_W])
			);
		end
	endgenerate

	always_comb
	begin
		ld = lq;
		// Pins are taken on the rising link edge; decode works one cycle later
		ld.cke_q = i_cke;
		ld.cs_n_q = i_cs_n;
		ld.cmd_q = {i_ras_n, i_cas_n, i_we_n};
		ld.ba_q = i_group_select_bits;
		ld.addr_q = i_addr;
		ld.term_req_q = i_on_die_termination_control;
		ld.dq_q = i_data_lines;
		ld.wmask_q = {i_upper_byte_write_mask, i_lower_byte_write_mask};
		ld.strb_q = {i_upper_byte_strobe, i_lower_byte_strobe};
		ld.strb_n_q = {i_upper_byte_strobe_n, i_lower_byte_strobe_n};
		ld.term_on = lq.term_req_q;
		cmd_ok = lq.cke_q && !lq.cs_n_q;
		for (int l = 0; l < LANES; l++)
		begin
			// A differential strobe with both legs equal is mid-swing: hold
			if (lq.diff_mode && (lq.strb_q[l] == lq.strb_n_q[l]))
				vs[l] = lq.strb_prev[l];
			else
				vs[l] = lq.strb_q[l];
			edge_seen[l] = vs[l] != lq.strb_prev[l];
			ld.strb_prev[l] = vs[l];
			lane_we[l] = 1'b0;
			lane_waddr[l] = {lq.wr_base[MEM_AW-1:2], lq.wr_base[1:0] + lq.wr_beat[l]};
			if (lq.wr_act[l] && lq.cke_q && edge_seen[l])
			begin
				lane_we[l] = !lq.wmask_q[l];
				ld.wr_beat[l] = lq.wr_beat[l] + 2'h1;
				if (lq.wr_beat[l] == BURST_LAST)
					ld.wr_act[l] = 1'b0;
			end
		end
		case (lq.rd_state)
			RD_IDLE:
			begin
				ld.dq_oe = 1'b0;
			end
			RD_WAIT:
			begin
				if (lq.lat_cnt == 2'h0)
				begin
					ld.rd_state = RD_BURST;
					ld.dq_out = rdata;
					ld.dq_oe = 1'b1;
					ld.strb_oe = 1'b1;
					ld.strb_out = '1;
					ld.rd_beat = 2'h0;
					ld.rd_addr = {lq.rd_addr[MEM_AW-1:2], lq.rd_addr[1:0] + 2'h1};
				end
				else
					ld.lat_cnt = lq.lat_cnt - 2'h1;
			end
			RD_BURST:
			begin
				if (lq.rd_beat == BURST_LAST)
				begin
					ld.rd_state = RD_IDLE;
					ld.dq_oe = 1'b0;
					ld.strb_oe = 1'b0;
					ld.strb_out = '0;
				end
				else
				begin
					// Data and strobe leave the same flop edge: edge aligned
					ld.rd_beat = lq.rd_beat + 2'h1;
					ld.dq_out = rdata;
					ld.strb_out = ~lq.strb_out;
					ld.rd_addr = {lq.rd_addr[MEM_AW-1:2], lq.rd_addr[1:0] + 2'h1};
				end
			end
			default:
			begin
				ld.rd_state = RD_IDLE;
			end
		endcase
		if (cmd_ok)
		begin
			case (lq.cmd_q)
				CMD_ACT:
				begin
					ld.row_open[lq.ba_q] = 1'b1;
					ld.open_row[lq.ba_q] = lq.addr_q;
				end
				CMD_PRE:
				begin
					if (lq.addr_q[AP_BIT])
						ld.row_open = OPEN_RST;
					else
						ld.row_open[lq.ba_q] = 1'b0;
				end
				CMD_WR:
				begin
					// Only the low column bits index the small store
					if (lq.row_open[lq.ba_q])
					begin
						ld.wr_act = '1;
						ld.wr_beat = '0;
						ld.wr_base = {lq.ba_q, lq.addr_q[1:0]};
						if (lq.addr_q[AP_BIT])
							ld.row_open[lq.ba_q] = 1'b0;
					end
				end
				CMD_RD:
				begin
					if (lq.row_open[lq.ba_q] && (lq.rd_state == RD_IDLE))
					begin
						ld.rd_state = RD_WAIT;
						ld.lat_cnt = RD_WAIT_CYCLES;
						ld.rd_addr = {lq.ba_q, lq.addr_q[1:0]};
						if (lq.addr_q[AP_BIT])
							ld.row_open[lq.ba_q] = 1'b0;
					end
				end
				CMD_MRS:
				begin
					if (lq.ba_q == CFG1_SEL)
						ld.diff_mode = lq.addr_q[DIFF_BIT];
				end
				default:
				begin
					ld.diff_mode = lq.diff_mode;
				end
			endcase
		end
		ld.strb_out_n = ~ld.strb_out;
		ld.strbn_oe = ld.strb_oe && ld.diff_mode;
	end

	always_ff @(posedge i_link_clk or posedge lk_rst)
	begin
		if (lk_rst)
			lq <= '0;
		else
			lq <= ld;
	end

	always_comb
	begin
		md = mq;
		// Bits cross one by one; a bank map seen mid-change settles a cycle later
		md.banks_s1 = lq.row_open;
		md.banks_s2 = mq.banks_s1;
		md.diff_s1 = lq.diff_mode;
		md.diff_s2 = mq.diff_s1;
		md.term_s1 = lq.term_on;
		md.term_s2 = mq.term_s1;
	end

	always_ff @(posedge i_mclk or posedge i_rst)
	begin
		if (i_rst)
			mq <= '0;
		else
			mq <= md;
	end

	assign o_data_lines = lq.dq_out;
	assign o_data_lines_oe = lq.dq_oe;
	assign o_lower_byte_strobe = lq.strb_out[0];
	assign o_upper_byte_strobe = lq.strb_out[1];
	assign o_lower_byte_strobe_n = lq.strb_out_n[0];
	assign o_upper_byte_strobe_n = lq.strb_out_n[1];
	assign o_lower_byte_strobe_oe = lq.strb_oe;
	assign o_upper_byte_strobe_oe = lq.strb_oe;
	assign o_lower_byte_strobe_n_oe = lq.strbn_oe;
	assign o_upper_byte_strobe_n_oe = lq.strbn_oe;
	assign o_term_enable = lq.term_on;
	assign o_open_banks = mq.banks_s2;
	assign o_diff_strobe_mode = mq.diff_s2;
	assign o_term_status = mq.term_s2;

	desel_ignored_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		lq.cs_n_q |=> $stable(lq.row_open) && $stable(lq.diff_mode))
		else $error("deselected command changed state");
	act_opens_row_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(cmd_ok && lq.cmd_q == CMD_ACT) |=>
		lq.row_open[$past(lq.ba_q)] && lq.open_row[$past(lq.ba_q)] == $past(lq.addr_q))
		else $error("activate did not open the row");
	pre_closes_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(cmd_ok && lq.cmd_q == CMD_PRE && !lq.addr_q[AP_BIT]) |=>
		!lq.row_open[$past(lq.ba_q)])
		else $error("precharge left bank open");
	term_follow_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		lq.term_req_q |=> o_term_enable ##1 (o_term_enable == $past(lq.term_req_q)))
		else $error("termination did not follow control");
	mask_blocks_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(lq.wr_act[0] && lq.cke_q && edge_seen[0] && lq.wmask_q[0]) |-> !lane_we[0])
		else $error("masked byte was written");
	read_burst_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		$rose(o_data_lines_oe) |-> o_data_lines_oe[*4] ##1 !o_data_lines_oe)
		else $error("read burst not four beats");
	strobe_toggle_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(o_data_lines_oe && $past(o_data_lines_oe)) |->
		o_lower_byte_strobe != $past(o_lower_byte_strobe))
		else $error("read strobe did not toggle with data");
	read_latency_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(cmd_ok && lq.cmd_q == CMD_RD && lq.row_open[lq.ba_q] && lq.rd_state == RD_IDLE)
		|-> ##4 $rose(o_data_lines_oe))
		else $error("read data not at fixed latency");
	cke_freeze_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		!lq.cke_q |=> $stable(lq.row_open) && $stable(lq.wr_act))
		else $error("state moved with clock enable low");
	diff_mode_a: assert property (@(posedge i_link_clk) disable iff (lk_rst)
		(cmd_ok && lq.cmd_q == CMD_MRS && lq.ba_q == CFG1_SEL) |=>
		lq.diff_mode == $past(lq.addr_q[DIFF_BIT]))
		else $error("differential mode bit not taken");
endmodule // dpi_top
`default_nettype wire

// File: verification/dpi_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module dpi_ctrl_model
	import dpi_pkg::*;
(
	input wire logic i_link_clk,
	output logic o_cke,
	output logic o_cs_n,
	output logic [2:0] o_cmd,
	output logic [dpi_pkg::BANK_W-1:0] o_bank,
	output logic [dpi_pkg::ADDR_W-1:0] o_addr,
	output logic o_term_req,
	output logic [dpi_pkg::DQ_W-1:0] o_dq,
	output logic [1:0] o_mask,
	output logic [1:0] o_strb,
	output logic [1:0] o_strb_n
);
	initial
	begin
		o_cke = 1'b0;
		o_cs_n = 1'b1;
		o_cmd = 3'h7;
		o_bank = 2'h0;
		o_addr = 13'h0000;
		o_term_req = 1'b0;
		o_dq = 16'h0000;
		o_mask = 2'h0;
		o_strb = 2'h0;
		o_strb_n = 2'h3;
	end

	task automatic set_cke(input logic v);
		@(negedge i_link_clk);
		o_cke = v;
	endtask

	task automatic set_term(input logic v);
		@(negedge i_link_clk);
		o_term_req = v;
	endtask

	// Pins move on the falling edge so the rising edge samples them settled
	task automatic cmd(input logic cs_n, input logic [2:0] c, input logic [1:0] b,
		input logic [12:0] a);
		@(negedge i_link_clk);
		o_cs_n = cs_n;
		o_cmd = c;
		o_bank = b;
		o_addr = a;
		@(negedge i_link_clk);
		o_cs_n = 1'b1;
		o_addr = ~a;
	endtask

	// Single-edge model: one strobe flip per link cycle, one beat each
	task automatic wr(input logic [1:0] b, input logic [12:0] a, input logic [3:0][15:0] d,
		input logic [3:0][1:0] m);
		cmd(1'b0, CMD_WR, b, a);
		for (int i = 0; i < 4; i++)
		begin
			@(negedge i_link_clk);
			o_dq = d[i];
			o_mask = m[i];
			o_strb = ~o_strb;
			// Complement leg must differ from the true leg or the beat is held
			o_strb_n = ~o_strb;
		end
		@(negedge i_link_clk);
		o_dq = ~o_dq;
		o_mask = 2'h0;
	endtask
endmodule // dpi_ctrl_model
`default_nettype wire

// File: verification/ddr2_sdram_pin_interface_test.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
	begin \
		checks++; \
		if ((g) !== (e)) \
		begin \
			$display("CHECK FAILED %s exp %h got %h", nm, e, g); \
			num_errors++; \
		end \
	end
module ddr2_sdram_pin_interface_test;
	import dpi_pkg::*;
	logic i_mclk, i_link_clk, i_rst, cke, cs_n, term_req;
	logic [2:0] cmd;
	logic [1:0] bank, mask, strb, strb_n;
	logic [12:0] addr;
	logic [15:0] c_dq, d_dq, dq;
	logic d_oe, ls, lsn, ls_oe, lsn_oe, us, usn, us_oe, usn_oe, term, diff, term_st;
	logic [3:0] open_b;
	logic [3:0][15:0] exp_w;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	// Shared lines resolve from whoever has its enable up
	assign dq = d_oe ? d_dq : c_dq;

	dpi_ctrl_model u_dpi_ctrl_model (.i_link_clk(i_link_clk), .o_cke(cke), .o_cs_n(cs_n),
		.o_cmd(cmd), .o_bank(bank), .o_addr(addr), .o_term_req(term_req), .o_dq(c_dq),
		.o_mask(mask), .o_strb(strb), .o_strb_n(strb_n));

	dpi_top u_dpi_top (.i_mclk(i_mclk), .i_rst(i_rst), .i_link_clk(i_link_clk), .i_cke(cke),
		.i_cs_n(cs_n), .i_ras_n(cmd[2]), .i_cas_n(cmd[1]), .i_we_n(cmd[0]),
		.i_group_select_bits(bank), .i_addr(addr), .i_on_die_termination_control(term_req),
		.i_data_lines(dq), .i_lower_byte_write_mask(mask[0]),
		.i_upper_byte_write_mask(mask[1]), .i_lower_byte_strobe(ls_oe ? ls : strb[0]),
		.i_lower_byte_strobe_n(lsn_oe ? lsn : strb_n[0]),
		.i_upper_byte_strobe(us_oe ? us : strb[1]),
		.i_upper_byte_strobe_n(usn_oe ? usn : strb_n[1]), .o_data_lines(d_dq),
		.o_data_lines_oe(d_oe), .o_lower_byte_strobe(ls), .o_lower_byte_strobe_n(lsn),
		.o_lower_byte_strobe_oe(ls_oe), .o_lower_byte_strobe_n_oe(lsn_oe),
		.o_upper_byte_strobe(us), .o_upper_byte_strobe_n(usn), .o_upper_byte_strobe_oe(us_oe),
		.o_upper_byte_strobe_n_oe(usn_oe), .o_term_enable(term), .o_open_banks(open_b),
		.o_diff_strobe_mode(diff), .o_term_status(term_st));

	initial
	begin
		i_mclk = 1'b0;
		forever #2.5 i_mclk = ~i_mclk;
	end

	initial
	begin
		i_link_clk = 1'b0;
		#3.1;
		forever #62.5 i_link_clk = ~i_link_clk;
	end

	task automatic end_sim();
		if (num_errors == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Whole run needs about 2100 system cycles
	always @(posedge i_mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			end_sim();
		end
	end

	task automatic lw(input int k);
		repeat (k) @(negedge i_link_clk);
	endtask

	task automatic rd_chk(input logic [12:0] a, input logic [3:0][15:0] e, input logic diff_on);
		int n;
		u_dpi_ctrl_model.cmd(1'b0, CMD_RD, 2'h1, a);
		n = 0;
		while (d_oe !== 1'b1 && n < 8)
		begin
			lw(1);
			n++;
		end
		// Fixed latency: four link cycles from command pins to the first beat
		`CHK("read start", 32'h4, n)
		for (int i = 0; i < 4; i++)
		begin
			`CHK("read data", e[i], d_dq)
			`CHK("read strobe", {~i[0], ~i[0]}, {us, ls})
			`CHK("strobe drive", 2'h3, {us_oe, ls_oe})
			`CHK("complement drive", {diff_on, diff_on}, {usn_oe, lsn_oe})
			if (diff_on)
				`CHK("complement strobe", {i[0], i[0]}, {usn, lsn})
			lw(1);
		end
		`CHK("read end", 1'b0, d_oe)
	endtask

	task automatic t_act();
		u_dpi_ctrl_model.cmd(1'b0, CMD_ACT, 2'h1, 13'h1abc);
		u_dpi_ctrl_model.cmd(1'b1, CMD_ACT, 2'h2, 13'h0155);
		u_dpi_ctrl_model.set_cke(1'b0);
		u_dpi_ctrl_model.cmd(1'b0, CMD_ACT, 2'h3, 13'h0aaa);
		u_dpi_ctrl_model.set_cke(1'b1);
		lw(2);
		`CHK("open banks", 4'h2, open_b)
	endtask

	// Second burst masks bytes so the first burst shows through
	task automatic t_wr();
		logic [3:0][15:0] a;
		logic [3:0][15:0] b;
		logic [3:0][1:0] m;
		a = {16'h4433, 16'h2211, 16'h8877, 16'h6655};
		b = {16'hddcc, 16'hbbaa, 16'h9988, 16'h7766};
		m = {2'h3, 2'h1, 2'h2, 2'h0};
		u_dpi_ctrl_model.wr(2'h1, 13'h0000, a, 8'h00);
		u_dpi_ctrl_model.wr(2'h1, 13'h0000, b, m);
		for (int i = 0; i < 4; i++)
		begin
			exp_w[i][7:0] = m[i][0] ? a[i][7:0] : b[i][7:0];
			exp_w[i][15:8] = m[i][1] ? a[i][15:8] : b[i][15:8];
		end
		rd_chk(13'h0000, exp_w, 1'b0);
	endtask

	// Differential write masks word two, so the older word shows through there
	task automatic t_ap();
		logic [3:0][15:0] c;
		c = {16'h0f1e, 16'h2d3c, 16'h4b5a, 16'h6978};
		u_dpi_ctrl_model.cmd(1'b0, CMD_MRS, 2'h1, 13'h0400);
		lw(2);
		`CHK("diff mode", 1'b1, diff)
		u_dpi_ctrl_model.wr(2'h1, 13'h0000, c, 8'h30);
		rd_chk(13'h0402, {c[1], c[0], c[3], exp_w[2]}, 1'b1);
		`CHK("auto precharge", 4'h0, open_b)
	endtask

	task automatic t_pre();
		u_dpi_ctrl_model.cmd(1'b0, CMD_ACT, 2'h0, 13'h0010);
		u_dpi_ctrl_model.cmd(1'b0, CMD_ACT, 2'h3, 13'h0020);
		lw(2);
		`CHK("two open", 4'h9, open_b)
		u_dpi_ctrl_model.cmd(1'b0, CMD_PRE, 2'h0, 13'h0000);
		lw(2);
		`CHK("one closed", 4'h8, open_b)
		u_dpi_ctrl_model.cmd(1'b0, CMD_PRE, 2'h1, 13'h0400);
		lw(2);
		`CHK("all closed", 4'h0, open_b)
	endtask

	task automatic t_term();
		u_dpi_ctrl_model.set_term(1'b1);
		lw(1);
		`CHK("term early", 1'b0, term)
		lw(2);
		`CHK("term on", 1'b1, term)
		`CHK("term status", 1'b1, term_st)
		u_dpi_ctrl_model.set_term(1'b0);
		lw(3);
		`CHK("term off", 1'b0, term)
		`CHK("term status off", 1'b0, term_st)
	endtask

	// Link domain needs running edges to leave reset
	initial
	begin
		i_rst = 1'b1;
		repeat (6) @(negedge i_mclk);
		lw(2);
		@(negedge i_mclk);
		i_rst = 1'b0;
		u_dpi_ctrl_model.set_cke(1'b1);
		lw(3);
		t_act();
		t_wr();
		t_ap();
		t_pre();
		t_term();
		end_sim();
	end
endmodule // ddr2_sdram_pin_interface_test
`default_nettype wire
